// ==== tar_pkg.sv ====
package tar_pkg;
  // Register offsets (byte addresses on the plain port)
  localparam logic [7:0] RADIO_STATE_STATUS_ADDR = 8'h01;
  localparam logic [7:0] STATE_CONTROL_ADDR      = 8'h02;
  localparam logic [7:0] TRX_CTRL_ONE_ADDR       = 8'h04;
  localparam logic [7:0] CCA_MODE_ADDR           = 8'h08;
  localparam logic [7:0] CCA_LEVEL_ADDR          = 8'h09;
  localparam logic [7:0] IRQ_MASK_ADDR           = 8'h0E;
  localparam logic [7:0] IRQ_STATUS_ADDR         = 8'h0F;
  localparam logic [7:0] AUTO_ACK_CTRL_ADDR      = 8'h17;
  localparam logic [7:0] RETRY_CTRL_ADDR         = 8'h2C;
  localparam logic [7:0] SEED_LOW_ADDR           = 8'h2D;
  localparam logic [7:0] SEED_HIGH_ADDR          = 8'h2E;
  localparam logic [7:0] BACKOFF_EXP_ADDR        = 8'h2F;

  // State command codes
  localparam logic [4:0] CMD_TX_START   = 5'h02;
  localparam logic [4:0] CMD_FORCE_OFF  = 5'h03;
  localparam logic [4:0] CMD_RADIO_OFF  = 5'h08;
  localparam logic [4:0] CMD_PLL_ON     = 5'h09;
  localparam logic [4:0] CMD_AACK_ON    = 5'h16;
  localparam logic [4:0] CMD_RETRY_ON   = 5'h19;

  // Radio state codes
  localparam logic [4:0] ST_RADIO_OFF   = 5'h08;
  localparam logic [4:0] ST_PLL_ON      = 5'h09;
  localparam logic [4:0] ST_AACK_BUSY   = 5'h11;
  localparam logic [4:0] ST_RETRY_BUSY  = 5'h12;
  localparam logic [4:0] ST_AACK_ON     = 5'h16;
  localparam logic [4:0] ST_RETRY_IDLE  = 5'h19;

  // Transaction result codes
  localparam logic [2:0] RES_SUCCESS    = 3'h0;
  localparam logic [2:0] RES_PENDING    = 3'h1;
  localparam logic [2:0] RES_CHAN_FAIL  = 3'h3;
  localparam logic [2:0] RES_NO_ACK     = 3'h5;
  localparam logic [2:0] RES_INVALID    = 3'h7;

  // Field positions
  localparam int RES_LSB          = 5;
  localparam int CSMA_RETRY_LSB   = 1;
  localparam int FRAME_RETRY_LSB  = 4;
  localparam int ACK_REQ_BIT      = 5;
  localparam logic [2:0] CSMA_NO_ACCESS = 3'h7;

  // Interrupt bit positions
  localparam int IRQ_PLL_LOCK   = 0;
  localparam int IRQ_RX_START   = 2;
  localparam int IRQ_COMPLETION = 3;
  localparam int IRQ_ADDR_MATCH = 5;

  // Reset values
  localparam logic [7:0] RETRY_CTRL_RST  = 8'h38;
  localparam logic [7:0] BACKOFF_EXP_RST = 8'h53;
  localparam logic [7:0] SEED_LOW_RST    = 8'hEA;
  localparam logic [7:0] REG_ZERO_RST    = 8'h00;
  localparam logic [15:0] LFSR_RST       = 16'hACE1;

  // Timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int ACK_WAIT_US     = 864;
  localparam int ACK_WAIT_CYC    = (ACK_WAIT_US * (CLK_HZ / 1_000_000));
  localparam int SYMBOL_NS       = 16_000;
  localparam int SYMBOL_CYC      = SYMBOL_NS / 100;
  localparam int UNIT_BACKOFF_SYM = 20;

  // Radio-side event bundle from the modem
  typedef struct packed {
    logic tx_done;
    logic cca_done;
    logic cca_idle;
    logic rx_phr;
    logic rx_end;
    logic rx_is_ack;
    logic rx_addr_ok;
    logic rx_fcs_ok;
    logic rx_pending;
  } tar_radio_ev_t;

  // Requests to the modem
  typedef struct packed {
    logic tx_go;
    logic cca_go;
    logic rx_enable;
    logic fb_write_en;
  } tar_radio_req_t;
endpackage

// ==== tar_top.sv ====
`timescale 1ns/1ps
// Behaviour
// - Start in retry mode runs channel access, then sends the buffered frame.
// - Busy channel retried to CSMA limit; then abort with result 3.
// - Bit 5 of first payload octet decides whether an ack is expected.
// - With ack expected, receive is enabled after sending to await the ack.
// - Frame buffer is never written during the whole transaction.
// - While awaiting ack, every non-ack frame is discarded.
// - No ack within 864 us repeats whole transaction until frame limit exceeded.
// - All retries without ack give result 5 and completion interrupt.
// - Valid ack gives result 0, or 1 when its pending flag is set.
// - No ack requested: completion right after sending, result success.
// - CSMA limit 7 skips channel access and tries only once.
// - Status reads busy-retry during transaction, then retry-idle.
// - Completion interrupt only after the whole transaction ends.
// - Auto-ack receive raises start, address-match, and completion on good FCS.
// - Completion withheld for frames failing address filter or FCS.
// - Ack frames never raise address-match or completion.
// - Entering an extended mode from radio-off raises PLL lock interrupt.
// - Starting a procedure sets the result to invalid, code 7.
module tar_top (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    clk_en,
  // Register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  // Pins
  input  wire logic                    sleep_transmit_pin,
  output logic                         irq_out,
  // Modem side
  input  wire tar_pkg::tar_radio_ev_t  radio_ev,
  input  wire logic [7:0]              fb_first_octet,
  output tar_pkg::tar_radio_req_t      radio_req
);

  typedef enum logic [2:0] {
    TAR_IDLE   = 3'b000,
    TAR_BACK   = 3'b001,
    TAR_CCA    = 3'b011,
    TAR_SEND   = 3'b010,
    TAR_ACKW   = 3'b110,
    TAR_DONE   = 3'b111
  } tar_state_t;

  tar_state_t  st_q;
  logic [4:0]  mode_q;
  logic [2:0]  result_q;
  logic [7:0]  ctrl1_q, cca_mode_q, cca_thr_q, mask_q, irq_st_q, aack_q;
  logic [7:0]  retry_q, seed_lo_q, seed_hi_q, be_q;
  logic [2:0]  csma_cnt_q;
  logic [3:0]  frame_cnt_q;
  logic [15:0] lfsr_q;
  logic [15:0] wait_q;
  logic [7:0]  bo_units_q;
  logic [7:0]  sym_q;
  logic [1:0]  slp_sync_q;
  logic        slp_prev_q;
  logic [7:0]  irq_set;
  logic        start_evt;
  logic        wr_cmd;
  logic [2:0]  max_csma;
  logic [3:0]  max_frame;
  logic        no_csma;
  logic [2:0]  csma_cnt_inc;
  logic [3:0]  frame_cnt_inc;

  // Back-off units drawn from random bits, masked to 2^min(BE,8) - 1
  function automatic logic [7:0] tar_backoff(input logic [15:0] rnd, input logic [3:0] be);
    logic [7:0] m;
    m = 8'hFF >> (4'd8 - ((be > 4'd8) ? 4'd8 : be));
    return rnd[7:0] & m;
  endfunction

  assign max_csma      = retry_q[tar_pkg::CSMA_RETRY_LSB +: 3];
  assign max_frame     = retry_q[tar_pkg::FRAME_RETRY_LSB +: 4];
  assign no_csma       = (max_csma == tar_pkg::CSMA_NO_ACCESS);
  assign csma_cnt_inc  = csma_cnt_q + 3'd1;
  assign frame_cnt_inc = frame_cnt_q + 4'd1;
  assign wr_cmd        = reg_wr && (reg_addr == tar_pkg::STATE_CONTROL_ADDR);

  // Pin synchroniser; edge taken from the second stage only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slp_sync_q <= 2'b00;
      slp_prev_q <= 1'b0;
    end else if (clk_en) begin
      slp_sync_q <= {slp_sync_q[0], sleep_transmit_pin};
      slp_prev_q <= slp_sync_q[1];
    end
  end

  // Start by pin rising edge or transmit-start command
  assign start_evt = (mode_q == tar_pkg::ST_RETRY_IDLE) && (st_q == TAR_IDLE) &&
                     ((slp_sync_q[1] && !slp_prev_q) ||
                      (wr_cmd && reg_wdata[4:0] == tar_pkg::CMD_TX_START));

  // Configuration registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl1_q    <= tar_pkg::REG_ZERO_RST;
      cca_mode_q <= tar_pkg::REG_ZERO_RST;
      cca_thr_q  <= tar_pkg::REG_ZERO_RST;
      mask_q     <= tar_pkg::REG_ZERO_RST;
      aack_q     <= tar_pkg::REG_ZERO_RST;
      retry_q    <= tar_pkg::RETRY_CTRL_RST;
      seed_lo_q  <= tar_pkg::SEED_LOW_RST;
      seed_hi_q  <= tar_pkg::REG_ZERO_RST;
      be_q       <= tar_pkg::BACKOFF_EXP_RST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == tar_pkg::TRX_CTRL_ONE_ADDR) begin
        ctrl1_q <= reg_wdata;
      end else if (reg_addr == tar_pkg::CCA_MODE_ADDR) begin
        cca_mode_q <= reg_wdata;
      end else if (reg_addr == tar_pkg::CCA_LEVEL_ADDR) begin
        cca_thr_q <= reg_wdata;
      end else if (reg_addr == tar_pkg::IRQ_MASK_ADDR) begin
        mask_q <= reg_wdata;
      end else if (reg_addr == tar_pkg::AUTO_ACK_CTRL_ADDR) begin
        aack_q <= reg_wdata;
      end else if (reg_addr == tar_pkg::RETRY_CTRL_ADDR) begin
        retry_q <= reg_wdata;
      end else if (reg_addr == tar_pkg::SEED_LOW_ADDR) begin
        seed_lo_q <= reg_wdata;
      end else if (reg_addr == tar_pkg::SEED_HIGH_ADDR) begin
        seed_hi_q <= reg_wdata;
      end else if (reg_addr == tar_pkg::BACKOFF_EXP_ADDR) begin
        be_q <= reg_wdata;
      end
    end
  end

  // Radio mode: commands move between off, PLL-on and the extended modes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= tar_pkg::ST_RADIO_OFF;
    end else if (clk_en && wr_cmd) begin
      if (reg_wdata[4:0] == tar_pkg::CMD_FORCE_OFF ||
          reg_wdata[4:0] == tar_pkg::CMD_RADIO_OFF) begin
        mode_q <= tar_pkg::ST_RADIO_OFF;
      end else if (st_q == TAR_IDLE && reg_wdata[4:0] == tar_pkg::CMD_PLL_ON) begin
        mode_q <= tar_pkg::ST_PLL_ON;
      end else if (st_q == TAR_IDLE && reg_wdata[4:0] == tar_pkg::CMD_RETRY_ON) begin
        mode_q <= tar_pkg::ST_RETRY_IDLE;
      end else if (st_q == TAR_IDLE && reg_wdata[4:0] == tar_pkg::CMD_AACK_ON) begin
        mode_q <= tar_pkg::ST_AACK_ON;
      end
    end
  end

  // Interrupt events of this cycle
  always_comb begin
    irq_set = 8'h00;
    if (wr_cmd && mode_q == tar_pkg::ST_RADIO_OFF && st_q == TAR_IDLE &&
        (reg_wdata[4:0] == tar_pkg::CMD_RETRY_ON ||
         reg_wdata[4:0] == tar_pkg::CMD_AACK_ON)) begin
      irq_set[tar_pkg::IRQ_PLL_LOCK] = 1'b1;
    end
    if (mode_q == tar_pkg::ST_AACK_ON) begin
      irq_set[tar_pkg::IRQ_RX_START]   = radio_ev.rx_phr;
      irq_set[tar_pkg::IRQ_ADDR_MATCH] = radio_ev.rx_end && radio_ev.rx_addr_ok &&
                                         !radio_ev.rx_is_ack;
      irq_set[tar_pkg::IRQ_COMPLETION] = radio_ev.rx_end && radio_ev.rx_addr_ok &&
                                         radio_ev.rx_fcs_ok && !radio_ev.rx_is_ack;
    end
    if (st_q == TAR_DONE) begin
      irq_set[tar_pkg::IRQ_COMPLETION] = 1'b1;
    end
  end

  // Sticky interrupt status, cleared by reading; a new event wins over the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_st_q <= tar_pkg::REG_ZERO_RST;
      irq_out  <= 1'b0;
    end else if (clk_en) begin
      if (reg_rd && reg_addr == tar_pkg::IRQ_STATUS_ADDR) begin
        irq_st_q <= irq_set;
      end else begin
        irq_st_q <= irq_st_q | irq_set;
      end
      irq_out <= |((irq_st_q | irq_set) & mask_q);
    end
  end

  // Random source seeded from the seed registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lfsr_q <= tar_pkg::LFSR_RST;
    end else if (clk_en) begin
      if (reg_wr && (reg_addr == tar_pkg::SEED_LOW_ADDR)) begin
        lfsr_q <= {seed_hi_q, reg_wdata} | 16'h0001;
      end else begin
        lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      end
    end
  end

  // Retry-transmit sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q        <= TAR_IDLE;
      result_q    <= tar_pkg::RES_SUCCESS;
      csma_cnt_q  <= 3'd0;
      frame_cnt_q <= 4'd0;
      wait_q      <= 16'd0;
      bo_units_q  <= 8'd0;
      sym_q       <= 8'd0;
      radio_req   <= '0;
    end else if (clk_en) begin
      radio_req.tx_go       <= 1'b0;
      radio_req.cca_go      <= 1'b0;
      radio_req.fb_write_en <= 1'b0;
      case (st_q)
        TAR_IDLE: begin
          if (start_evt) begin
            result_q    <= tar_pkg::RES_INVALID;
            frame_cnt_q <= 4'd0;
            csma_cnt_q  <= 3'd0;
            if (no_csma) begin
              st_q            <= TAR_SEND;
              radio_req.tx_go <= 1'b1;
            end else begin
              st_q       <= TAR_BACK;
              bo_units_q <= tar_backoff(lfsr_q, be_q[3:0]);
              sym_q      <= 8'd0;
              wait_q     <= 16'd0;
            end
          end else if (wr_cmd && (reg_wdata[4:0] == tar_pkg::CMD_RETRY_ON ||
                                  reg_wdata[4:0] == tar_pkg::CMD_AACK_ON)) begin
            result_q <= tar_pkg::RES_INVALID;
          end
        end
        TAR_BACK: begin
          if (bo_units_q == 8'd0) begin
            st_q             <= TAR_CCA;
            radio_req.cca_go <= 1'b1;
          end else if (wait_q == 16'(tar_pkg::SYMBOL_CYC - 1)) begin
            wait_q <= 16'd0;
            if (sym_q == 8'(tar_pkg::UNIT_BACKOFF_SYM - 1)) begin
              sym_q      <= 8'd0;
              bo_units_q <= bo_units_q - 8'd1;
            end else begin
              sym_q <= sym_q + 8'd1;
            end
          end else begin
            wait_q <= wait_q + 16'd1;
          end
        end
        TAR_CCA: begin
          if (radio_ev.cca_done) begin
            if (radio_ev.cca_idle) begin
              st_q            <= TAR_SEND;
              radio_req.tx_go <= 1'b1;
            end else if (csma_cnt_q >= max_csma) begin
              result_q <= tar_pkg::RES_CHAN_FAIL;
              st_q     <= TAR_DONE;
            end else begin
              csma_cnt_q <= csma_cnt_inc;
              st_q       <= TAR_BACK;
              bo_units_q <= tar_backoff(lfsr_q, be_q[3:0]);
            end
          end
        end
        TAR_SEND: begin
          if (radio_ev.tx_done) begin
            frame_cnt_q <= frame_cnt_inc;
            wait_q      <= 16'd0;
            if (fb_first_octet[tar_pkg::ACK_REQ_BIT]) begin
              st_q                <= TAR_ACKW;
              radio_req.rx_enable <= 1'b1;
            end else begin
              result_q <= tar_pkg::RES_SUCCESS;
              st_q     <= TAR_DONE;
            end
          end
        end
        TAR_ACKW: begin
          wait_q <= wait_q + 16'd1;
          if (radio_ev.rx_end && radio_ev.rx_is_ack && radio_ev.rx_fcs_ok) begin
            result_q            <= radio_ev.rx_pending ? tar_pkg::RES_PENDING
                                                       : tar_pkg::RES_SUCCESS;
            st_q                <= TAR_DONE;
            radio_req.rx_enable <= 1'b0;
          end else if (wait_q == 16'(tar_pkg::ACK_WAIT_CYC - 1)) begin
            radio_req.rx_enable <= 1'b0;
            if (no_csma || frame_cnt_q > max_frame) begin
              result_q <= tar_pkg::RES_NO_ACK;
              st_q     <= TAR_DONE;
            end else begin
              csma_cnt_q <= 3'd0;
              st_q       <= TAR_BACK;
              bo_units_q <= tar_backoff(lfsr_q, be_q[3:0]);
              sym_q      <= 8'd0;
              wait_q     <= 16'd0;
            end
          end
          // Other received frames are simply ignored here
        end
        TAR_DONE: begin
          st_q <= TAR_IDLE;
        end
        default: begin
          st_q <= TAR_IDLE;
        end
      endcase
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (!reg_rd) begin
        reg_rdata <= 8'h00;
      end else if (reg_addr == tar_pkg::RADIO_STATE_STATUS_ADDR) begin
        reg_rdata <= {3'b000, (st_q != TAR_IDLE) ? tar_pkg::ST_RETRY_BUSY : mode_q};
      end else if (reg_addr == tar_pkg::STATE_CONTROL_ADDR) begin
        reg_rdata <= {result_q, 5'h00};
      end else if (reg_addr == tar_pkg::TRX_CTRL_ONE_ADDR) begin
        reg_rdata <= ctrl1_q;
      end else if (reg_addr == tar_pkg::CCA_MODE_ADDR) begin
        reg_rdata <= cca_mode_q;
      end else if (reg_addr == tar_pkg::CCA_LEVEL_ADDR) begin
        reg_rdata <= cca_thr_q;
      end else if (reg_addr == tar_pkg::IRQ_MASK_ADDR) begin
        reg_rdata <= mask_q;
      end else if (reg_addr == tar_pkg::IRQ_STATUS_ADDR) begin
        reg_rdata <= irq_st_q;
      end else if (reg_addr == tar_pkg::AUTO_ACK_CTRL_ADDR) begin
        reg_rdata <= aack_q;
      end else if (reg_addr == tar_pkg::RETRY_CTRL_ADDR) begin
        reg_rdata <= retry_q;
      end else if (reg_addr == tar_pkg::SEED_LOW_ADDR) begin
        reg_rdata <= seed_lo_q;
      end else if (reg_addr == tar_pkg::SEED_HIGH_ADDR) begin
        reg_rdata <= seed_hi_q;
      end else if (reg_addr == tar_pkg::BACKOFF_EXP_ADDR) begin
        reg_rdata <= be_q;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // Checks
  property p_fb_never_written;
    @(posedge clk) disable iff (!rstn) radio_req.fb_write_en == 1'b0;
  endproperty
  a_fb_never_written: assert property (p_fb_never_written) else $error("buffer written");

  property p_start_invalid;
    @(posedge clk) disable iff (!rstn) (clk_en && start_evt) |=> result_q == tar_pkg::RES_INVALID;
  endproperty
  a_start_invalid: assert property (p_start_invalid) else $error("result not invalid");

  property p_nocsma_direct;
    @(posedge clk) disable iff (!rstn)
      (clk_en && start_evt && no_csma) |=> (st_q == TAR_SEND && radio_req.tx_go);
  endproperty
  a_nocsma_direct: assert property (p_nocsma_direct) else $error("csma not skipped");

  property p_done_irq;
    @(posedge clk) disable iff (!rstn)
      (clk_en && st_q == TAR_DONE) |=> irq_st_q[tar_pkg::IRQ_COMPLETION];
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("no completion irq");

  property p_chan_fail;
    @(posedge clk) disable iff (!rstn)
      (clk_en && st_q == TAR_CCA && radio_ev.cca_done && !radio_ev.cca_idle &&
       csma_cnt_q >= max_csma) |=> (result_q == tar_pkg::RES_CHAN_FAIL && st_q == TAR_DONE);
  endproperty
  a_chan_fail: assert property (p_chan_fail) else $error("no access failure");

  property p_ack_pending;
    @(posedge clk) disable iff (!rstn)
      (clk_en && st_q == TAR_ACKW && radio_ev.rx_end && radio_ev.rx_is_ack &&
       radio_ev.rx_fcs_ok && radio_ev.rx_pending) |=> result_q == tar_pkg::RES_PENDING;
  endproperty
  a_ack_pending: assert property (p_ack_pending) else $error("pending not reported");

  property p_noack_success;
    @(posedge clk) disable iff (!rstn)
      (clk_en && st_q == TAR_SEND && radio_ev.tx_done && !fb_first_octet[tar_pkg::ACK_REQ_BIT])
      |=> (result_q == tar_pkg::RES_SUCCESS && st_q == TAR_DONE);
  endproperty
  a_noack_success: assert property (p_noack_success) else $error("no-ack path wrong");

  property p_ack_rx_on;
    @(posedge clk) disable iff (!rstn)
      (clk_en && st_q == TAR_SEND && radio_ev.tx_done && fb_first_octet[tar_pkg::ACK_REQ_BIT])
      |=> (st_q == TAR_ACKW && radio_req.rx_enable);
  endproperty
  a_ack_rx_on: assert property (p_ack_rx_on) else $error("receive not enabled");

  property p_ack_no_match;
    @(posedge clk) disable iff (!rstn)
      radio_ev.rx_is_ack |-> !irq_set[tar_pkg::IRQ_ADDR_MATCH];
  endproperty
  a_ack_no_match: assert property (p_ack_no_match) else $error("ack raised match");

  c_success: cover property (@(posedge clk) disable iff (!rstn)
    st_q == TAR_DONE && result_q == tar_pkg::RES_SUCCESS);
  c_noack: cover property (@(posedge clk) disable iff (!rstn)
    st_q == TAR_DONE && result_q == tar_pkg::RES_NO_ACK);
  c_chan: cover property (@(posedge clk) disable iff (!rstn)
    st_q == TAR_DONE && result_q == tar_pkg::RES_CHAN_FAIL);
  c_backoff: cover property (@(posedge clk) disable iff (!rstn)
    st_q == TAR_BACK && bo_units_q != 8'd0);
endmodule

// ==== tar_modem_model.sv ====
`timescale 1ns/1ps
// Far side: modem and remote node answering sends, channel checks and ack waits
module tar_modem_model (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // Requests and scenario controls
  input  wire tar_pkg::tar_radio_req_t radio_req,
  input  wire logic [1:0]             ack_mode,
  input  wire logic                   pend,
  input  wire logic                   busy,
  // Events and tallies
  output tar_pkg::tar_radio_ev_t      ev,
  output logic [7:0]                  tx_n,
  output logic [7:0]                  cca_n,
  output logic                        rx_seen,
  output logic                        fbw_seen
);
  logic [7:0] tx_t;
  logic [3:0] cca_t;
  logic [7:0] rx_t;

  // Strobes last one cycle; qualifiers toggle outside them so stale values never help
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ev <= '0;
      tx_t <= 8'h00;
      cca_t <= 4'h0;
      rx_t <= 8'h00;
    end else begin
      ev <= tar_pkg::tar_radio_ev_t'(~ev & 9'h04F);
      tx_t <= radio_req.tx_go ? 8'h14 : tx_t - 8'((tx_t != 8'h00));
      cca_t <= radio_req.cca_go ? 4'h8 : cca_t - 4'((cca_t != 4'h0));
      rx_t <= radio_req.rx_enable ? rx_t + 8'((rx_t != 8'hFF)) : 8'h00;
      if (tx_t == 8'h01) ev.tx_done <= 1'b1;
      if (cca_t == 4'h1) begin
        ev.cca_done <= 1'b1;
        ev.cca_idle <= ~busy;
      end
      // Stray data frame during the ack wait, then the ack itself
      if ((rx_t == 8'h32 && ack_mode == 2'h2) || (rx_t == 8'h64 && ack_mode != 2'h0)) begin
        ev.rx_end <= 1'b1;
        ev.rx_is_ack <= (rx_t == 8'h64);
        ev.rx_addr_ok <= 1'b1;
        ev.rx_fcs_ok <= 1'b1;
        ev.rx_pending <= pend;
      end
    end
  end

  // Tallies of requests seen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_n <= 8'h00;
      cca_n <= 8'h00;
      rx_seen <= 1'b0;
      fbw_seen <= 1'b0;
    end else begin
      tx_n <= tx_n + 8'(radio_req.tx_go);
      cca_n <= cca_n + 8'(radio_req.cca_go);
      rx_seen <= rx_seen | radio_req.rx_enable;
      fbw_seen <= fbw_seen | radio_req.fb_write_en;
    end
  end
endmodule

// ==== tx_auto_retry_csma_tb.sv ====
`timescale 1ns/1ps
module tx_auto_retry_csma_tb;
  logic                   clk = 1'b0;
  logic                   rstn = 1'b0;
  logic [7:0]             reg_addr = 8'h00;
  logic [7:0]             reg_wdata = 8'h00;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [7:0]             reg_rdata;
  logic                   pin = 1'b0;
  logic                   irq_out;
  logic [7:0]             fb = 8'h00;
  tar_pkg::tar_radio_req_t radio_req;
  tar_pkg::tar_radio_ev_t ev_m;
  tar_pkg::tar_radio_ev_t ev_t = '0;
  logic                   tb_sel = 1'b0;
  logic [1:0]             ack_mode = 2'h0;
  logic                   pend = 1'b0;
  logic                   busy = 1'b0;
  logic [7:0]             tx_n;
  logic [7:0]             cca_n;
  logic                   rx_seen;
  logic                   fbw_seen;
  logic [7:0]             t0;
  logic [7:0]             c0;
  int                     bad_count = 0;
  int                     check_count = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  tar_top u_dut (.clk, .rstn, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sleep_transmit_pin(pin), .irq_out, .radio_ev(tb_sel ? ev_t : ev_m),
    .fb_first_octet(fb), .radio_req);
  tar_modem_model u_far (.clk, .rstn, .radio_req, .ack_mode, .pend, .busy, .ev(ev_m),
    .tx_n, .cca_n, .rx_seen, .fbw_seen);

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, "read data");
  endtask
  // Bounded wait for the interrupt pin, then interrupt status and clear, result, radio state
  task automatic done_chk(input logic [2:0] res);
    int i;
    for (i = 0; i < 30000 && irq_out !== 1'b1; i++) @(posedge clk);
    chk({7'h00, irq_out}, 8'h01, "completion pin");
    rchk(tar_pkg::IRQ_STATUS_ADDR, 8'h08);
    rchk(tar_pkg::STATE_CONTROL_ADDR, {res, 5'h00});
    rchk(tar_pkg::RADIO_STATE_STATUS_ADDR, {3'h0, tar_pkg::ST_RETRY_IDLE});
  endtask
  // One received frame in auto-ack mode: header, then end with its flags
  task automatic rxf(input logic a, input logic f, input logic k);
    @(posedge clk);
    ev_t.rx_phr <= 1'b1;
    @(posedge clk);
    ev_t.rx_phr <= 1'b0;
    ev_t.rx_end <= 1'b1;
    ev_t.rx_addr_ok <= a;
    ev_t.rx_fcs_ok <= f;
    ev_t.rx_is_ack <= k;
    @(posedge clk);
    ev_t <= '0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    cyc(60000);
    bad_count++;
    final_report();
  end

  initial begin
    int i;
    cyc(20);
    rstn <= 1'b1;
    rchk(tar_pkg::RADIO_STATE_STATUS_ADDR, {3'h0, tar_pkg::ST_RADIO_OFF});
    rchk(tar_pkg::RETRY_CTRL_ADDR, tar_pkg::RETRY_CTRL_RST);
    rchk(tar_pkg::BACKOFF_EXP_ADDR, tar_pkg::BACKOFF_EXP_RST);
    rchk(tar_pkg::SEED_LOW_ADDR, tar_pkg::SEED_LOW_RST);
    rchk(8'h3F, 8'h00);
    wr(tar_pkg::CCA_LEVEL_ADDR, 8'h5A);
    rchk(tar_pkg::CCA_LEVEL_ADDR, 8'h5A);
    wr(tar_pkg::IRQ_MASK_ADDR, 8'h09);
    wr(tar_pkg::BACKOFF_EXP_ADDR, 8'h00);
    wr(tar_pkg::RETRY_CTRL_ADDR, 8'h0E);
    wr(tar_pkg::STATE_CONTROL_ADDR, {3'h0, tar_pkg::CMD_RETRY_ON});
    cyc(4);
    chk({7'h00, irq_out}, 8'h01, "lock pin");
    rchk(tar_pkg::IRQ_STATUS_ADDR, 8'h01);
    // Single attempt, no ack asked, started by command
    t0 = tx_n;
    c0 = cca_n;
    wr(tar_pkg::STATE_CONTROL_ADDR, {3'h0, tar_pkg::CMD_TX_START});
    rchk(tar_pkg::RADIO_STATE_STATUS_ADDR, {3'h0, tar_pkg::ST_RETRY_BUSY});
    rchk(tar_pkg::STATE_CONTROL_ADDR, {tar_pkg::RES_INVALID, 5'h00});
    done_chk(tar_pkg::RES_SUCCESS);
    chk(tx_n - t0, 8'h01, "sends");
    chk(cca_n - c0, 8'h00, "channel checks");
    // Ack asked, pin start, stray frame before an ack with pending set
    @(posedge clk);
    fb <= 8'h20;
    ack_mode <= 2'h2;
    pend <= 1'b1;
    pin <= 1'b1;
    cyc(6);
    pin <= 1'b0;
    done_chk(tar_pkg::RES_PENDING);
    chk({6'h00, rx_seen, fbw_seen}, 8'h02, "ack wait and buffer");
    // Busy channel, CSMA limit 1
    wr(tar_pkg::RETRY_CTRL_ADDR, 8'h02);
    wr(tar_pkg::BACKOFF_EXP_ADDR, 8'h01);
    busy <= 1'b1;
    ack_mode <= 2'h0;
    t0 = tx_n;
    c0 = cca_n;
    wr(tar_pkg::STATE_CONTROL_ADDR, {3'h0, tar_pkg::CMD_TX_START});
    done_chk(tar_pkg::RES_CHAN_FAIL);
    chk(cca_n - c0, 8'h02, "channel checks");
    chk(tx_n - t0, 8'h00, "sends");
    // No ack ever, frame limit 1
    wr(tar_pkg::RETRY_CTRL_ADDR, 8'h10);
    wr(tar_pkg::BACKOFF_EXP_ADDR, 8'h00);
    busy <= 1'b0;
    t0 = tx_n;
    c0 = cca_n;
    wr(tar_pkg::STATE_CONTROL_ADDR, {3'h0, tar_pkg::CMD_TX_START});
    for (i = 0; i < 200 && tx_n == t0; i++) @(posedge clk);
    cyc(8600);
    chk(tx_n - t0, 8'h01, "early resend");
    chk({7'h00, irq_out}, 8'h00, "early completion");
    done_chk(tar_pkg::RES_NO_ACK);
    chk(tx_n - t0, 8'h02, "sends");
    chk(cca_n - c0, 8'h02, "channel checks");
    // Auto-ack receive interrupts
    wr(tar_pkg::STATE_CONTROL_ADDR, {3'h0, tar_pkg::CMD_RADIO_OFF});
    wr(tar_pkg::STATE_CONTROL_ADDR, {3'h0, tar_pkg::CMD_AACK_ON});
    rchk(tar_pkg::STATE_CONTROL_ADDR, {tar_pkg::RES_INVALID, 5'h00});
    wr(tar_pkg::IRQ_MASK_ADDR, 8'h2D);
    cyc(4);
    rchk(tar_pkg::RADIO_STATE_STATUS_ADDR, {3'h0, tar_pkg::ST_AACK_ON});
    rchk(tar_pkg::IRQ_STATUS_ADDR, 8'h01);
    @(posedge clk);
    tb_sel <= 1'b1;
    rxf(1'b1, 1'b0, 1'b0);
    rchk(tar_pkg::IRQ_STATUS_ADDR, 8'h24);
    rxf(1'b1, 1'b1, 1'b0);
    rchk(tar_pkg::IRQ_STATUS_ADDR, 8'h2C);
    rxf(1'b1, 1'b1, 1'b1);
    rchk(tar_pkg::IRQ_STATUS_ADDR, 8'h04);
    rxf(1'b0, 1'b1, 1'b0);
    rchk(tar_pkg::IRQ_STATUS_ADDR, 8'h04);
    final_report();
  end
endmodule
